// ### core/tec_pkg.sv
// Purpose: Shared constants and types for the three-axis encoder counter
// Assumes: Core clock of 40 MHz
// Notes: All dividers are derived from the core clock rate
package tec_pkg;
  localparam int CLK_HZ = 40_000_000;
  localparam int CNT_W = 24;
  localparam int NUM_AXES = 3;
  localparam int NUM_DIN = 5;
  localparam int NUM_SRC = 8;
  localparam int FLT_STAGES = 4;
  localparam int MULT_W = 8;
  localparam int TB_W = 22;
  localparam int FLT_W = 5;

  // Filter sampling rates
  localparam int FLT_HZ_8M = 8_000_000;
  localparam int FLT_HZ_4M = 4_000_000;
  localparam int FLT_HZ_2M = 2_000_000;
  localparam logic [FLT_W-1:0] FLT_DIV_8M = FLT_W'(CLK_HZ / FLT_HZ_8M);
  localparam logic [FLT_W-1:0] FLT_DIV_4M = FLT_W'(CLK_HZ / FLT_HZ_4M);
  localparam logic [FLT_W-1:0] FLT_DIV_2M = FLT_W'(CLK_HZ / FLT_HZ_2M);

  // Timer base rates
  localparam int TB_HZ_10 = 10;
  localparam int TB_HZ_1K = 1_000;
  localparam int TB_HZ_10K = 10_000;
  localparam int TB_DIV_10 = CLK_HZ / TB_HZ_10;
  localparam int TB_DIV_1K = CLK_HZ / TB_HZ_1K;
  localparam logic [TB_W-1:0] TB_DIV_10K = TB_W'(CLK_HZ / TB_HZ_10K);

  // Reset values and the counter limit
  localparam logic [CNT_W-1:0] CNT_RST = 24'h000000;
  localparam logic [CNT_W-1:0] CNT_MAX = 24'hffffff;
  localparam logic [MULT_W-1:0] MULT_MIN = 8'h01;

  // Interrupt source positions
  localparam int SRC_OVF0 = 0;
  localparam int SRC_IDX0 = 3;
  localparam int SRC_DIN = 6;
  localparam int SRC_SHARED = 7;
  localparam int DIN_SHARED = 1;

  typedef enum logic [1:0] {
    TEC_MODE_QUAD = 2'b00,
    TEC_MODE_PDIR = 2'b01,
    TEC_MODE_UPDN = 2'b10
  } tec_mode_t;

  typedef enum logic [1:0] {
    TEC_QUAD_X1 = 2'b00,
    TEC_QUAD_X2 = 2'b01,
    TEC_QUAD_X4 = 2'b10
  } tec_quad_t;

  typedef enum logic [1:0] {
    TEC_FLT_8M = 2'b00,
    TEC_FLT_4M = 2'b01,
    TEC_FLT_2M = 2'b10
  } tec_flt_t;

  typedef enum logic [1:0] {
    TEC_TB_10 = 2'b00,
    TEC_TB_1K = 2'b01,
    TEC_TB_10K = 2'b10
  } tec_tb_t;
endpackage

// ### core/tec_axis.sv
// Purpose: One encoder axis: input filter, decoder and 24-bit counter
// Assumes: smp_tick is a one-cycle pulse at the filter sampling rate
// Notes: Carry and borrow are combinational pulses for cascading
`timescale 1ns/1ps
module tec_axis (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Sampling and control
  input wire logic smp_tick,
  input wire tec_pkg::tec_mode_t mode,
  input wire tec_pkg::tec_quad_t quad,
  input wire logic casc_en,
  input wire logic casc_up,
  input wire logic casc_dn,
  input wire logic clr,
  // Encoder pins: bit 0 phase A, bit 1 phase B, bit 2 index
  input wire logic [2:0] pins,
  // Results
  output logic [tec_pkg::CNT_W-1:0] count,
  output logic carry,
  output logic borrow,
  output logic idx_evt
);
  logic [2:0] s1;
  logic [2:0] s2;
  logic [2:0] s3;
  logic [2:0] held;
  logic [2:0] stg [tec_pkg::FLT_STAGES];
  logic [2:0] flt;
  logic [2:0] prev;
  logic [2:0] all_one;
  logic [2:0] all_zero;
  wire [2:0] agree = ~(s2 ^ s3);
  wire [2:0] chg = flt ^ prev;
  wire [2:0] rise = flt & ~prev;
  wire both = chg[0] & chg[1];
  wire q_up = flt[0] ^ prev[1];
  wire x4_step = (chg[0] | chg[1]) & ~both;
  wire x2_step = chg[0] & ~both;
  wire x1_step = rise[0] & ~chg[1];
  wire q_step = (quad == tec_pkg::TEC_QUAD_X4) ? x4_step :
                (quad == tec_pkg::TEC_QUAD_X2) ? x2_step : x1_step;
  // Decoder ignores the index so it works with or without one
  wire dec_up = (mode == tec_pkg::TEC_MODE_QUAD) ? (q_step & q_up) :
                (mode == tec_pkg::TEC_MODE_PDIR) ? (rise[0] & flt[1]) :
                (rise[0] & ~rise[1]);
  wire dec_dn = (mode == tec_pkg::TEC_MODE_QUAD) ? (q_step & ~q_up) :
                (mode == tec_pkg::TEC_MODE_PDIR) ? (rise[0] & ~flt[1]) :
                (rise[1] & ~rise[0]);
  wire inc = casc_en ? casc_up : dec_up;
  wire dec = casc_en ? casc_dn : dec_dn;

  always_comb begin
    all_one = 3'h7;
    all_zero = 3'h7;
    for (int i = 0; i < tec_pkg::FLT_STAGES; i++) begin
      all_one = all_one & stg[i];
      all_zero = all_zero & ~stg[i];
    end
  end

  // A clear or a cancelled step must not ripple into the next axis
  assign carry = inc & ~dec & ~clr & (count == tec_pkg::CNT_MAX);
  assign borrow = dec & ~inc & ~clr & (count == tec_pkg::CNT_RST);
  assign idx_evt = rise[2];

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s1 <= 3'h0;
      s2 <= 3'h0;
      s3 <= 3'h0;
      held <= 3'h0;
      flt <= 3'h0;
      prev <= 3'h0;
      for (int i = 0; i < tec_pkg::FLT_STAGES; i++) begin
        stg[i] <= 3'h0;
      end
    end else begin
      s1 <= pins;
      s2 <= s1;
      s3 <= s2;
      held <= (held & ~agree) | (s3 & agree);
      if (smp_tick) begin
        stg[0] <= held;
        for (int i = 1; i < tec_pkg::FLT_STAGES; i++) begin
          stg[i] <= stg[i-1];
        end
      end
      flt <= (flt | all_one) & ~all_zero;
      prev <= flt;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      count <= tec_pkg::CNT_RST;
    end else if (clr) begin
      count <= tec_pkg::CNT_RST;
    end else if (inc & ~dec) begin
      count <= count + 24'h000001;
    end else if (dec & ~inc) begin
      count <= count - 24'h000001;
    end
  end
endmodule // tec_axis

// ### core/tec_top.sv
// Purpose: Three-axis encoder counter with timer and interrupt selection
// Assumes: 40 MHz CORE_CLK; control ports are static or CORE_CLK-synchronous
// Notes: Interrupt outputs are one-cycle pulses, treat as rising-edge events
`timescale 1ns/1ps
module tec_top #(
  parameter int TB_DIV_10 = tec_pkg::TB_DIV_10,
  parameter int TB_DIV_1K = tec_pkg::TB_DIV_1K
) (
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic ARST_N,
  // Encoder pins, axis one first
  input wire logic AXIS_ONE_PHASE_A,
  input wire logic AXIS_ONE_PHASE_B,
  input wire logic AXIS_ONE_INDEX,
  input wire logic AXIS_TWO_PHASE_A,
  input wire logic AXIS_TWO_PHASE_B,
  input wire logic AXIS_TWO_INDEX,
  input wire logic AXIS_THREE_PHASE_A,
  input wire logic AXIS_THREE_PHASE_B,
  input wire logic AXIS_THREE_INDEX,
  // Digital inputs
  input wire logic [tec_pkg::NUM_DIN-1:0] DIGITAL_IN,
  // Axis configuration
  input wire tec_pkg::tec_mode_t AXIS_MODE [tec_pkg::NUM_AXES],
  input wire tec_pkg::tec_quad_t AXIS_QUAD [tec_pkg::NUM_AXES],
  input wire logic [tec_pkg::NUM_AXES-1:0] COUNT_CLEAR,
  input wire logic CASCADE_ONE_TWO,
  input wire logic CASCADE_TWO_THREE,
  input wire tec_pkg::tec_flt_t FILTER_RATE,
  // Timer and interrupt configuration
  input wire tec_pkg::tec_tb_t TIMER_BASE,
  input wire logic [tec_pkg::MULT_W-1:0] TIMER_MULT,
  input wire logic SHARED_SRC_TIMER,
  input wire logic IRQ_ENABLE,
  input wire logic [2:0] IRQ_SELECT,
  // Results
  output logic [tec_pkg::CNT_W-1:0] COUNT_ONE,
  output logic [tec_pkg::CNT_W-1:0] COUNT_TWO,
  output logic [tec_pkg::CNT_W-1:0] COUNT_THREE,
  output logic [tec_pkg::NUM_DIN-1:0] DIGITAL_LEVEL,
  output logic [tec_pkg::NUM_SRC-1:0] IRQ_SOURCE,
  output logic IRQ
);
  localparam logic [tec_pkg::TB_W-1:0] TB_D10 = tec_pkg::TB_W'(TB_DIV_10);
  localparam logic [tec_pkg::TB_W-1:0] TB_D1K = tec_pkg::TB_W'(TB_DIV_1K);

  logic [tec_pkg::FLT_W-1:0] flt_cnt;
  logic smp_tick;
  logic [tec_pkg::TB_W-1:0] tb_cnt;
  logic tb_tick;
  logic [tec_pkg::MULT_W-1:0] mult_cnt;
  logic tmr_evt;
  logic [tec_pkg::NUM_DIN-1:0] d1;
  logic [tec_pkg::NUM_DIN-1:0] d2;
  logic [tec_pkg::NUM_DIN-1:0] d3;
  logic [tec_pkg::NUM_DIN-1:0] din_prev;
  logic [tec_pkg::CNT_W-1:0] count [tec_pkg::NUM_AXES];
  logic [tec_pkg::NUM_AXES-1:0] carry;
  logic [tec_pkg::NUM_AXES-1:0] borrow;
  logic [tec_pkg::NUM_AXES-1:0] idx_evt;

  // Filter sample divider: a slower rate trades input bandwidth for immunity
  wire [tec_pkg::FLT_W-1:0] flt_div =
    (FILTER_RATE == tec_pkg::TEC_FLT_8M) ? tec_pkg::FLT_DIV_8M :
    (FILTER_RATE == tec_pkg::TEC_FLT_4M) ? tec_pkg::FLT_DIV_4M :
    tec_pkg::FLT_DIV_2M;
  wire flt_wrap = (flt_cnt >= flt_div - 5'h01);

  // Time base divider; a larger count than the new limit wraps at once
  wire [tec_pkg::TB_W-1:0] tb_div =
    (TIMER_BASE == tec_pkg::TEC_TB_10) ? TB_D10 :
    (TIMER_BASE == tec_pkg::TEC_TB_1K) ? TB_D1K :
    tec_pkg::TB_DIV_10K;
  wire tb_wrap = (tb_cnt >= tb_div - 22'h000001);

  // A multiplier of zero is treated as one
  wire [tec_pkg::MULT_W-1:0] mult_eff =
    (TIMER_MULT < tec_pkg::MULT_MIN) ? tec_pkg::MULT_MIN : TIMER_MULT;
  wire mult_done = (mult_cnt <= tec_pkg::MULT_MIN);

  // Digital input stability and edges
  wire [tec_pkg::NUM_DIN-1:0] d_agree = ~(d2 ^ d3);
  wire [tec_pkg::NUM_DIN-1:0] din_rise = DIGITAL_LEVEL & ~din_prev;
  wire din_other = |(din_rise &
    ~(5'h01 << tec_pkg::DIN_SHARED));

  // Request vector, one bit per controller input
  wire shared_src = SHARED_SRC_TIMER ? tmr_evt :
                    din_rise[tec_pkg::DIN_SHARED];
  wire [tec_pkg::NUM_SRC-1:0] next_source =
    {shared_src, din_other, idx_evt, carry | borrow};
  wire next_irq = IRQ_ENABLE & next_source[IRQ_SELECT];

  wire [2:0] pins [tec_pkg::NUM_AXES];
  wire [tec_pkg::NUM_AXES-1:0] casc_en;
  wire [tec_pkg::NUM_AXES-1:0] casc_up;
  wire [tec_pkg::NUM_AXES-1:0] casc_dn;
  assign pins[0] = {AXIS_ONE_INDEX, AXIS_ONE_PHASE_B, AXIS_ONE_PHASE_A};
  assign pins[1] = {AXIS_TWO_INDEX, AXIS_TWO_PHASE_B, AXIS_TWO_PHASE_A};
  assign pins[2] = {AXIS_THREE_INDEX, AXIS_THREE_PHASE_B,
                    AXIS_THREE_PHASE_A};
  assign casc_en = {CASCADE_TWO_THREE, CASCADE_ONE_TWO, 1'b0};
  assign casc_up = {carry[1:0], 1'b0};
  assign casc_dn = {borrow[1:0], 1'b0};

  for (genvar g = 0; g < tec_pkg::NUM_AXES; g++) begin : g_axis
    tec_axis u_axis (
      .clk(CORE_CLK),
      .arst_n(ARST_N),
      .smp_tick(smp_tick),
      .mode(AXIS_MODE[g]),
      .quad(AXIS_QUAD[g]),
      .casc_en(casc_en[g]),
      .casc_up(casc_up[g]),
      .casc_dn(casc_dn[g]),
      .clr(COUNT_CLEAR[g]),
      .pins(pins[g]),
      .count(count[g]),
      .carry(carry[g]),
      .borrow(borrow[g]),
      .idx_evt(idx_evt[g])
    );
  end

  assign COUNT_ONE = count[0];
  assign COUNT_TWO = count[1];
  assign COUNT_THREE = count[2];

  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      flt_cnt <= 5'h00;
      smp_tick <= 1'b0;
    end else begin
      flt_cnt <= flt_wrap ? 5'h00 : flt_cnt + 5'h01;
      smp_tick <= flt_wrap;
    end
  end

  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      tb_cnt <= 22'h000000;
      tb_tick <= 1'b0;
    end else begin
      tb_cnt <= tb_wrap ? 22'h000000 : tb_cnt + 22'h000001;
      tb_tick <= tb_wrap;
    end
  end

  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      mult_cnt <= tec_pkg::MULT_MIN;
      tmr_evt <= 1'b0;
    end else begin
      tmr_evt <= tb_tick & mult_done;
      if (tb_tick) begin
        mult_cnt <= mult_done ? mult_eff : mult_cnt - 8'h01;
      end
    end
  end

  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      d1 <= 5'h00;
      d2 <= 5'h00;
      d3 <= 5'h00;
      DIGITAL_LEVEL <= 5'h00;
      din_prev <= 5'h00;
    end else begin
      d1 <= DIGITAL_IN;
      d2 <= d1;
      d3 <= d2;
      DIGITAL_LEVEL <= (DIGITAL_LEVEL & ~d_agree) | (d3 & d_agree);
      din_prev <= DIGITAL_LEVEL;
    end
  end

  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      IRQ_SOURCE <= 8'h00;
      IRQ <= 1'b0;
    end else begin
      IRQ_SOURCE <= next_source;
      IRQ <= next_irq;
    end
  end
endmodule // tec_top

// ### sim/tec_enc_model.sv
// Purpose: Encoder and index sensor partner for the three axes
// Assumes: Driven from the bench through its drive task
// Notes: Pins change just after a rising edge and then hold
`timescale 1ns/1ps
module tec_enc_model (
  // Clock
  input wire logic clk,
  // Encoder pins, one bit per axis
  output logic [2:0] a,
  output logic [2:0] b,
  output logic [2:0] z
);
  initial begin
    a = 3'h0;
    b = 3'h0;
    z = 3'h0;
  end
  // A hold shorter than the filter window never reaches the counter
  task automatic drive(input logic [2:0] na, input logic [2:0] nb,
      input logic [2:0] nz, input int hold);
    @(posedge clk);
    a <= na;
    b <= nb;
    z <= nz;
    repeat (hold) @(posedge clk);
  endtask
endmodule // tec_enc_model

// ### sim/tec_top_props.sv
// Purpose: Port-level checks for the three-axis encoder counter
// Assumes: Bound to tec_top; timer dividers follow the instance
// Notes: Timer spacing is judged only after one full steady interval
`timescale 1ns/1ps
module tec_top_props #(
  parameter int TB_DIV_10 = tec_pkg::TB_DIV_10,
  parameter int TB_DIV_1K = tec_pkg::TB_DIV_1K
) (
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic ARST_N,
  // Inputs watched
  input wire logic [tec_pkg::NUM_DIN-1:0] DIGITAL_IN,
  input wire logic [tec_pkg::NUM_AXES-1:0] COUNT_CLEAR,
  input wire logic CASCADE_ONE_TWO,
  input wire tec_pkg::tec_tb_t TIMER_BASE,
  input wire logic [tec_pkg::MULT_W-1:0] TIMER_MULT,
  input wire logic SHARED_SRC_TIMER,
  input wire logic IRQ_ENABLE,
  input wire logic [2:0] IRQ_SELECT,
  // Outputs watched
  input wire logic [tec_pkg::CNT_W-1:0] COUNT_ONE,
  input wire logic [tec_pkg::CNT_W-1:0] COUNT_TWO,
  input wire logic [tec_pkg::NUM_DIN-1:0] DIGITAL_LEVEL,
  input wire logic [tec_pkg::NUM_SRC-1:0] IRQ_SOURCE,
  input wire logic IRQ
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!ARST_N);
  logic [10:0] cfg;
  logic [10:0] cfg_q;
  logic seen;
  int unsigned gap;
  int unsigned base_div;
  int unsigned per;
  assign cfg = {SHARED_SRC_TIMER, TIMER_BASE, TIMER_MULT};
  assign base_div = (TIMER_BASE == tec_pkg::TEC_TB_10) ? TB_DIV_10 :
    (TIMER_BASE == tec_pkg::TEC_TB_1K) ? TB_DIV_1K : tec_pkg::TB_DIV_10K;
  assign per = base_div * ((TIMER_MULT == 8'h00) ? 32'd1 : 32'(TIMER_MULT));
  // A config change restarts the judgement: the old reload is still running
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      cfg_q <= '0;
      seen <= 1'b0;
      gap <= 0;
    end else begin
      cfg_q <= cfg;
      gap <= IRQ_SOURCE[7] ? 1 : gap + 1;
      if (cfg != cfg_q) seen <= 1'b0;
      else if (IRQ_SOURCE[7]) seen <= 1'b1;
    end
  end
  a_irq_routed: assert property (
    IRQ == ($past(IRQ_ENABLE) && IRQ_SOURCE[$past(IRQ_SELECT)]))
    else $error("interrupt output does not follow the selected source");
  a_src_single: assert property (
    (IRQ_SOURCE & $past(IRQ_SOURCE)) == 8'h00)
    else $error("interrupt source held longer than one cycle");
  a_clear_zero: assert property (
    COUNT_CLEAR[0] && COUNT_CLEAR[1] |=> COUNT_ONE == 0 && COUNT_TWO == 0)
    else $error("counter not held at zero by clear");
  a_count_step: assert property (
    !$past(COUNT_CLEAR[0]) && $changed(COUNT_ONE) |->
    COUNT_ONE - $past(COUNT_ONE) == 24'h000001 ||
    COUNT_ONE - $past(COUNT_ONE) == 24'hffffff)
    else $error("counter moved by more than one");
  a_cascade_carry: assert property (
    $past(CASCADE_ONE_TWO) && !$past(COUNT_CLEAR[1]) && $changed(COUNT_TWO)
    |-> ($past(COUNT_ONE) == 24'hffffff && COUNT_ONE == 24'h000000) ||
    ($past(COUNT_ONE) == 24'h000000 && COUNT_ONE == 24'hffffff))
    else $error("upper counter moved without a wrap below");
  a_timer_spacing: assert property (
    IRQ_SOURCE[7] && seen && SHARED_SRC_TIMER && cfg == cfg_q |->
    gap == per)
    else $error("timer interval differs from base times multiplier");
  a_din_level: assert property (
    $stable(DIGITAL_IN)[*8] |-> DIGITAL_LEVEL == DIGITAL_IN)
    else $error("digital level does not follow a steady input");
  a_din_shared: assert property (
    !SHARED_SRC_TIMER && $rose(DIGITAL_LEVEL[1]) |->
    ##[0:2] $past(IRQ_SOURCE[7]))
    else $error("shared source missed a rise of input one");
  a_din_other: assert property (
    $rose(DIGITAL_LEVEL[0]) |-> ##[0:2] $past(IRQ_SOURCE[6]))
    else $error("digital source missed a rise of input zero");
endmodule // tec_top_props
bind tec_top tec_top_props #(.TB_DIV_10(TB_DIV_10), .TB_DIV_1K(TB_DIV_1K))
  u_props (.CORE_CLK(CORE_CLK), .ARST_N(ARST_N), .DIGITAL_IN(DIGITAL_IN),
  .COUNT_CLEAR(COUNT_CLEAR), .CASCADE_ONE_TWO(CASCADE_ONE_TWO),
  .TIMER_BASE(TIMER_BASE), .TIMER_MULT(TIMER_MULT),
  .SHARED_SRC_TIMER(SHARED_SRC_TIMER), .IRQ_ENABLE(IRQ_ENABLE),
  .IRQ_SELECT(IRQ_SELECT), .COUNT_ONE(COUNT_ONE), .COUNT_TWO(COUNT_TWO),
  .DIGITAL_LEVEL(DIGITAL_LEVEL), .IRQ_SOURCE(IRQ_SOURCE), .IRQ(IRQ));

// ### sim/tb_tec_top.sv
// Purpose: Self-checking bench for the three-axis encoder counter
// Assumes: Axes one and three share pins; cascading starts at the clear
// Notes: Short timer dividers keep the run brief
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) \
  err($sformatf("got %h want %h", g, e)); end
module tb_tec_top;
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [2:0] pa, pb, pz;
  logic [4:0] din = 5'h00;
  tec_pkg::tec_mode_t mode [3];
  tec_pkg::tec_quad_t quad [3];
  logic [2:0] clr = 3'h0;
  logic casc12 = 1'b0;
  logic casc23 = 1'b0;
  tec_pkg::tec_flt_t rate = tec_pkg::TEC_FLT_8M;
  tec_pkg::tec_tb_t base = tec_pkg::TEC_TB_10K;
  logic [7:0] mult = 8'h02;
  logic shared = 1'b0;
  logic irq_en = 1'b0;
  logic [2:0] sel = 3'h0;
  logic [23:0] c1, c2, c3, prev1, exp1, exp_v;
  logic [4:0] lvl;
  logic [7:0] src;
  logic irq;
  logic [31:0] rnd = 32'hcc1f316b;
  logic [23:0] cnt_q [$];
  int irq_q [$];
  int n_errors = 0;
  int n_checks = 0;
  int hold;
  tec_enc_model enc (.clk(core_clk), .a(pa), .b(pb), .z(pz));
  tec_top #(.TB_DIV_10(40), .TB_DIV_1K(20)) dut (
    .CORE_CLK(core_clk), .ARST_N(arst_n), .AXIS_ONE_PHASE_A(pa[0]),
    .AXIS_ONE_PHASE_B(pb[0]), .AXIS_ONE_INDEX(pz[0]),
    .AXIS_TWO_PHASE_A(pa[1]), .AXIS_TWO_PHASE_B(pb[1]),
    .AXIS_TWO_INDEX(pz[1]), .AXIS_THREE_PHASE_A(pa[2]),
    .AXIS_THREE_PHASE_B(pb[2]), .AXIS_THREE_INDEX(pz[2]), .DIGITAL_IN(din),
    .AXIS_MODE(mode), .AXIS_QUAD(quad), .COUNT_CLEAR(clr),
    .CASCADE_ONE_TWO(casc12), .CASCADE_TWO_THREE(casc23), .FILTER_RATE(rate),
    .TIMER_BASE(base), .TIMER_MULT(mult), .SHARED_SRC_TIMER(shared),
    .IRQ_ENABLE(irq_en), .IRQ_SELECT(sel), .COUNT_ONE(c1), .COUNT_TWO(c2),
    .COUNT_THREE(c3), .DIGITAL_LEVEL(lvl), .IRQ_SOURCE(src), .IRQ(irq));
  always #12.5 core_clk = ~core_clk;
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  function automatic int delta(input tec_pkg::tec_mode_t m,
      input tec_pkg::tec_quad_t q, input logic oa, ob, na, nb);
    logic da, db;
    da = oa ^ na;
    db = ob ^ nb;
    if (m == tec_pkg::TEC_MODE_QUAD) begin
      if (da == db) return 0;
      if (q == tec_pkg::TEC_QUAD_X4 || (q == tec_pkg::TEC_QUAD_X2 && da) ||
          (da && na)) return (na ^ ob) ? 1 : -1;
      return 0;
    end
    if (m == tec_pkg::TEC_MODE_PDIR) return (da && na) ? (nb ? 1 : -1) : 0;
    return (da && na && !(db && nb)) ? 1 :
           (db && nb && !(da && na)) ? -1 : 0;
  endfunction
  task automatic err(input string s);
    n_errors++;
    $display("unexpected %0t: %s", $time, s);
  endtask
  task automatic close_out();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic drain(input int lim);
    int i;
    for (i = 0; i < lim && (cnt_q.size() + irq_q.size()) > 0; i++)
      @(posedge core_clk);
    if (i == lim) begin
      err("wait ran out");
      close_out();
    end
  endtask
  // Expectation is noted before the pins move, so the monitor never races
  task automatic step(input logic na, input logic nb, input logic nz);
    int d;
    d = delta(mode[0], quad[0], pa[0], pb[0], na, nb);
    if (d != 0) begin
      exp1 = exp1 + 24'(d);
      cnt_q.push_back(exp1);
    end
    rnd = lfsr(rnd);
    enc.drive({na, rnd[0], na}, {nb, rnd[1], nb}, {nz, rnd[2], nz}, hold);
  endtask
  always @(posedge core_clk) begin
    if (arst_n && c1 !== prev1) begin
      if (cnt_q.size() == 0) err("count moved");
      else begin
        exp_v = cnt_q.pop_front();
        `CHK(c1, exp_v)
      end
    end
    if (arst_n && irq === 1'b1) begin
      if (irq_q.size() == 0) err("stray interrupt");
      else begin
        void'(irq_q.pop_front());
        n_checks++;
      end
    end
    prev1 = c1;
  end
  initial begin
    exp1 = 24'h0;
    prev1 = 24'h0;
    foreach (mode[i]) begin
      mode[i] = tec_pkg::TEC_MODE_QUAD;
      quad[i] = tec_pkg::TEC_QUAD_X1;
    end
    repeat (16) @(posedge core_clk);
    arst_n <= 1'b1;
    repeat (2) @(posedge core_clk);
    `CHK({c1, c2, c3, lvl, src, irq}, 86'h0)
    for (int r = 0; r < 3; r++) begin
      rate <= tec_pkg::tec_flt_t'(r);
      hold = 4 * (int'(tec_pkg::FLT_DIV_8M) << r) + 12;
      for (int k = 0; k < 5; k++) begin
        foreach (mode[i]) begin
          mode[i] <= tec_pkg::tec_mode_t'(k < 3 ? 0 : k - 2);
          quad[i] <= tec_pkg::tec_quad_t'(k < 3 ? k : 0);
        end
        // The next expectation must be worked out with the new mode
        @(posedge core_clk);
        repeat (12) begin
          rnd = lfsr(rnd);
          if (k < 3) step(rnd[0], rnd[1], rnd[2]);
          else if (rnd[0]) step(!pa[0], pb[0], 1'b0);
          else step(pa[0], !pb[0], 1'b0);
        end
        enc.drive(~pa, pb, pz, (int'(tec_pkg::FLT_DIV_8M) << r) - 2);
        enc.drive(~pa, pb, pz, hold);
        drain(2000);
      end
    end
    if (exp1 != 24'h0) cnt_q.push_back(24'h0);
    exp1 = 24'h0;
    clr <= 3'h7;
    casc12 <= 1'b1;
    casc23 <= 1'b1;
    repeat (2) @(posedge core_clk);
    clr <= 3'h0;
    irq_en <= 1'b1;
    step(1'b0, 1'b0, 1'b0);
    drain(100);
    irq_q.push_back(1);
    step(1'b0, 1'b1, 1'b0);
    drain(200);
    `CHK(c2, 24'hffffff)
    `CHK(c3, 24'hffffff)
    irq_q.push_back(1);
    step(1'b1, 1'b1, 1'b0);
    drain(200);
    `CHK(c2, 24'h000000)
    sel <= 3'h3;
    irq_q.push_back(1);
    step(1'b1, 1'b1, 1'b1);
    step(1'b1, 1'b1, 1'b0);
    drain(200);
    sel <= 3'h6;
    repeat (10) begin
      rnd = lfsr(rnd);
      if ((rnd[4:0] & ~din & 5'h1d) != 5'h00) irq_q.push_back(1);
      din <= rnd[4:0];
      repeat (12) @(posedge core_clk);
      `CHK(lvl, din)
    end
    drain(20);
    shared <= 1'b1;
    sel <= 3'h7;
    irq_en <= 1'b1;
    for (int t = 2; t >= 0; t--) begin
      base <= tec_pkg::tec_tb_t'(t);
      mult <= (t == 2) ? 8'h02 : (t == 1) ? 8'hff : 8'h01;
      repeat (3) irq_q.push_back(1);
      drain(40000);
    end
    `CHK(c3, exp1)
    close_out();
  end
endmodule // tb_tec_top
